/* File: hdl/iss_pkg.sv */
/*
 * Constants and carrier types for the two-wire slave status and control block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package iss_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
	localparam logic [7:0] OFS_ENABLE = 8'h0c;

	// ----------------------------------------------------------------
	// Field positions in the written word
	// ----------------------------------------------------------------
	localparam int POS_TX_SEL = 4;
	localparam int POS_TX_ACK = 3;
	localparam int POS_WAKE_EN = 1;
	localparam int POS_ENABLE = 0;
	localparam int POS_OWN_ADDR = 1;

	// ----------------------------------------------------------------
	// Values after reset and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_RESET = 8'h81;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_DRIVE = 4'h8;
	localparam logic [3:0] ACK_END = 4'h9;

	// Status and control fields, bit 7 first.
	typedef struct packed {
		logic done;
		logic match;
		logic busy;
		logic tx_sel;
		logic tx_ack;
		logic rw;
		logic wake_en;
		logic rx_ack;
	} iss_flags_t;

	typedef enum logic [7:0] {
		ST_IDLE = 8'b0000_0001,
		ST_ADDR = 8'b0000_0010,
		ST_ADDR_ACK = 8'b0000_0100,
		ST_RX = 8'b0000_1000,
		ST_RX_ACK = 8'b0001_0000,
		ST_TX = 8'b0010_0000,
		ST_TX_ACK = 8'b0100_0000,
		ST_SKIP = 8'b1000_0000
	} iss_state_t;

endpackage

/* File: hdl/iss_slave.sv */
/*
 * Slave-only two-wire serial interface: status and control flags, address
 * compare, byte shifting and acknowledge handling, with a Wishbone register port.
 * Assumes external pull-ups on SCL and SDA and a master that never stretches.
 */
// Overview of operation
// - Transfer-done is not cleared when a byte starts shifting; sets after each own-address, received or transmitted byte with interrupt.
// - A START clears transfer-done.
// - Software read of the data buffer clears transfer-done.
// - A STOP sets transfer-done.
// - Address-match is 1 on own address, 0 otherwise.
// - Bus-busy sets on START and clears on STOP.
// - Software direction select: 0 receive, 1 transmit.
// - On ninth clock after received byte, drive transmit-ack bit onto SDA.
// - Software clears transmit-ack before further bytes are received.
// - Read/write flag shows master direction: 1 master reads, 0 master writes.
// - With wake enable set, an own-address match wakes the device.
// - Software clears wake enable after such a wake-up.
// - After transmitting a byte, sample SDA on ninth clock into receive-ack.
// - Transmit while acknowledged; on no-acknowledge release SDA for STOP.
// - The eighth bit after START, the one after the seven address bits, is captured as read/write flag on an own-address match only.
// - Address bits arrive most significant first and are assembled so.
// - Own-address match sets address-match and raises the interrupt.
// - SDA falling while SCL high is START.
`timescale 1ns/10ps

module iss_slave (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic serial_irq,
	output logic wake_req
);

	// ----------------------------------------------------------------
	// Pin synchronisers and bus condition detection
	// ----------------------------------------------------------------
	logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_q <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_q <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_q <= sda_s2;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s2 & ~scl_q;
	assign scl_fall = ~scl_s2 & scl_q;
	assign start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
	assign stop_det = scl_s2 & scl_q & ~sda_q & sda_s2;

	// Open drain: the pin is only ever pulled low.
	assign sda_o = 1'b0;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	iss_pkg::iss_state_t state, next_state;
	iss_pkg::iss_flags_t flags, next_flags;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic [7:0] data_buf, next_data_buf;
	logic [6:0] own_addr, next_own_addr;
	logic enable, next_enable;
	logic next_sda_oe, next_irq, next_wake, next_ack;
	logic [31:0] next_dat;
	logic wb_req, wb_wr, data_rd, hw_set_done;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	assign data_rd = wb_req & ~wb_we_i & (wb_adr_i == iss_pkg::OFS_DATA);

	always_comb begin
		next_state = state;
		next_flags = flags;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_data_buf = data_buf;
		next_own_addr = own_addr;
		next_enable = enable;
		next_sda_oe = sda_oe;
		next_irq = 1'b0;
		next_wake = 1'b0;
		hw_set_done = 1'b0;
		next_ack = wb_req;
		next_dat = 32'h0000_0000;
		// Software side first, so that a hardware set in the same cycle wins.
		if (wb_wr) begin
			unique case (wb_adr_i)
				iss_pkg::OFS_STATUS_CTRL: begin
					next_flags.tx_sel = wb_dat_i[iss_pkg::POS_TX_SEL];
					next_flags.tx_ack = wb_dat_i[iss_pkg::POS_TX_ACK];
					next_flags.wake_en = wb_dat_i[iss_pkg::POS_WAKE_EN];
				end
				iss_pkg::OFS_DATA: next_data_buf = wb_dat_i[7:0];
				iss_pkg::OFS_OWN_ADDR: next_own_addr = wb_dat_i[iss_pkg::POS_OWN_ADDR +: 7];
				iss_pkg::OFS_ENABLE: next_enable = wb_dat_i[iss_pkg::POS_ENABLE];
				default: ;
			endcase
		end
		if (wb_req && !wb_we_i) begin
			unique case (wb_adr_i)
				iss_pkg::OFS_STATUS_CTRL: next_dat = {24'h00_0000, flags};
				iss_pkg::OFS_DATA: next_dat = {24'h00_0000, data_buf};
				iss_pkg::OFS_OWN_ADDR: next_dat = {24'h00_0000, own_addr, 1'b0};
				iss_pkg::OFS_ENABLE: next_dat = {31'h0000_0000, enable};
				default: next_dat = 32'h0000_0000;
			endcase
		end
		if (data_rd) begin
			next_flags.done = 1'b0;
		end
		// Link side.
		if (!enable) begin
			next_state = iss_pkg::ST_IDLE;
			next_sda_oe = 1'b0;
			next_flags.busy = 1'b0;
		end else if (start_det) begin
			next_flags.busy = 1'b1;
			next_flags.done = 1'b0;
			next_state = iss_pkg::ST_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_det) begin
			next_flags.busy = 1'b0;
			next_flags.done = 1'b1;
			hw_set_done = 1'b1;
			next_state = iss_pkg::ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
				iss_pkg::ST_IDLE: ;
				iss_pkg::ST_ADDR: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda_s2};
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == iss_pkg::LAST_BIT) begin
							if (shift[6:0] == own_addr) begin
								next_flags.match = 1'b1;
								next_flags.rw = sda_s2;
								next_flags.done = 1'b1;
								hw_set_done = 1'b1;
								next_irq = 1'b1;
								next_wake = flags.wake_en;
								next_state = iss_pkg::ST_ADDR_ACK;
							end else begin
								next_flags.match = 1'b0;
								next_state = iss_pkg::ST_SKIP;
							end
						end
					end
				end
				iss_pkg::ST_ADDR_ACK: begin
					if (scl_fall && bit_cnt == iss_pkg::ACK_DRIVE) begin
						next_sda_oe = 1'b1;
						next_bit_cnt = iss_pkg::ACK_END;
					end else if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (flags.tx_sel) begin
							next_state = iss_pkg::ST_TX;
							next_shift = data_buf;
							next_sda_oe = ~data_buf[7];
						end else begin
							next_state = iss_pkg::ST_RX;
							next_sda_oe = 1'b0;
						end
					end
				end
				iss_pkg::ST_RX: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda_s2};
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == iss_pkg::LAST_BIT) begin
							next_data_buf = {shift[6:0], sda_s2};
							next_flags.done = 1'b1;
							hw_set_done = 1'b1;
							next_irq = 1'b1;
							next_state = iss_pkg::ST_RX_ACK;
						end
					end
				end
				iss_pkg::ST_RX_ACK: begin
					if (scl_fall && bit_cnt == iss_pkg::ACK_DRIVE) begin
						next_sda_oe = ~flags.tx_ack;
						next_bit_cnt = iss_pkg::ACK_END;
					end else if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_bit_cnt = 4'h0;
						next_state = iss_pkg::ST_RX;
					end
				end
				iss_pkg::ST_TX: begin
					if (scl_rise) begin
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == iss_pkg::ACK_DRIVE) begin
						next_sda_oe = 1'b0;
						next_flags.done = 1'b1;
						hw_set_done = 1'b1;
						next_irq = 1'b1;
						next_state = iss_pkg::ST_TX_ACK;
					end else if (scl_fall) begin
						next_shift = {shift[6:0], 1'b0};
						next_sda_oe = ~shift[6];
					end
				end
				iss_pkg::ST_TX_ACK: begin
					if (scl_rise && bit_cnt == iss_pkg::ACK_DRIVE) begin
						next_flags.rx_ack = sda_s2;
						next_bit_cnt = iss_pkg::ACK_END;
					end else if (scl_fall && bit_cnt == iss_pkg::ACK_END) begin
						next_bit_cnt = 4'h0;
						if (!flags.rx_ack) begin
							next_state = iss_pkg::ST_TX;
							next_shift = data_buf;
							next_sda_oe = ~data_buf[7];
						end else begin
							next_state = iss_pkg::ST_SKIP;
						end
					end
				end
				iss_pkg::ST_SKIP: next_sda_oe = 1'b0;
				default: begin
					next_state = iss_pkg::ST_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= iss_pkg::ST_IDLE;
			flags <= iss_pkg::STATUS_RESET;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			data_buf <= iss_pkg::DATA_RESET;
			own_addr <= iss_pkg::OWN_ADDR_RESET;
			enable <= 1'b0;
			sda_oe <= 1'b0;
			serial_irq <= 1'b0;
			wake_req <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			state <= next_state;
			flags <= next_flags;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			data_buf <= next_data_buf;
			own_addr <= next_own_addr;
			enable <= next_enable;
			sda_oe <= next_sda_oe;
			serial_irq <= next_irq;
			wake_req <= next_wake;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic oe_may_change, rx_last, addr_last;
	assign oe_may_change = scl_fall | start_det | stop_det | ~enable;
	assign rx_last = enable & ~start_det & ~stop_det & scl_rise & (bit_cnt == iss_pkg::LAST_BIT);
	assign addr_last = rx_last & (state == iss_pkg::ST_ADDR);

	AST_DONE_AFTER_BYTE: assert property (rx_last && state == iss_pkg::ST_RX |=> flags.done && serial_irq) else $error("byte end did not set done");
	AST_START_CLEARS_DONE: assert property (enable && start_det && !data_rd |=> !flags.done) else $error("start did not clear done");
	AST_READ_CLEARS_DONE: assert property (data_rd && !hw_set_done |=> !flags.done ##1 !wb_ack_o) else $error("data read did not clear done");
	AST_STOP_SETS_DONE: assert property (enable && stop_det |=> flags.done && !flags.busy) else $error("stop did not set done");
	AST_ADDR_MATCH: assert property (addr_last |=> flags.match == ($past(shift[6:0]) == $past(own_addr))) else $error("address match wrong");
	AST_BUSY_ON_START: assert property (enable && start_det |=> flags.busy && state == iss_pkg::ST_ADDR) else $error("start did not set busy");
	AST_TX_ACK_DRIVE: assert property (enable && !start_det && !stop_det && state == iss_pkg::ST_RX_ACK && scl_fall && bit_cnt == iss_pkg::ACK_DRIVE |=> sda_oe == !$past(flags.tx_ack)) else $error("ack drive wrong");
	AST_RW_CAPTURE: assert property (addr_last && shift[6:0] == own_addr |=> flags.rw == $past(sda_s2)) else $error("direction not captured");
	AST_RX_ACK_SAMPLE: assert property (enable && !start_det && !stop_det && state == iss_pkg::ST_TX_ACK && scl_rise && bit_cnt == iss_pkg::ACK_DRIVE |=> flags.rx_ack == $past(sda_s2)) else $error("receive ack not sampled");
	AST_NACK_RELEASE: assert property (state == iss_pkg::ST_SKIP |-> ##1 !sda_oe) else $error("sda held after nack");
	AST_OE_STABLE: assert property ($changed(sda_oe) |-> $past(oe_may_change)) else $error("sda changed while scl high");
	AST_WAKE: assert property (wake_req |-> flags.match && flags.wake_en && serial_irq) else $error("wake without match");

	COV_RX_BYTE: cover property (state == iss_pkg::ST_RX_ACK && sda_oe);
	COV_TX_BYTE: cover property (state == iss_pkg::ST_TX_ACK ##1 state == iss_pkg::ST_TX);
	COV_MISMATCH: cover property (state == iss_pkg::ST_ADDR ##1 state == iss_pkg::ST_SKIP);
	COV_WAKE: cover property (wake_req);

endmodule

/* File: bench/iss_master_model.sv */
/*
 * Behavioural two-wire bus master that faces the slave block.
 * Assumes a pulled-up SDA wire resolved by the bench; SCL half period is 4 ref_clk.
 */
`timescale 1ns/10ps
module iss_master_model (
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	// ------------------------------------------------------------
	// Bus conditions
	// ------------------------------------------------------------
	// SCL rests high between frames, so the link clock stands still there.
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hp(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic start();
		sda <= 1'b1;
		hp(2);
		scl <= 1'b1;
		hp(4);
		sda <= 1'b0;
		hp(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		hp(2);
		sda <= 1'b0;
		hp(2);
		scl <= 1'b1;
		hp(4);
		sda <= 1'b1;
		hp(4);
	endtask
	// ------------------------------------------------------------
	// Bits and bytes
	// ------------------------------------------------------------
	// SDA only moves in the middle of the low phase, never while SCL is high.
	task automatic bit_io(input logic b, output logic r);
		hp(2);
		sda <= b;
		hp(2);
		scl <= 1'b1;
		hp(2);
		r = sda_line;
		hp(2);
		scl <= 1'b0;
	endtask
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack);
	endtask
	task automatic read_byte(input logic m_ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(m_ack, r);
	endtask
endmodule

/* File: bench/tb.sv */
/*
 * Self-checking bench for the slave status and control block.
 * Assumes the master model drives the link and the bench resolves the SDA wire.
 */
`timescale 1ns/10ps
module tb;
	localparam logic [6:0] ADDR = 7'h2a;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [3:0] wsel = 4'hf;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, scl, m_sda, sda_o, sda_oe, serial_irq, wake_req, b;
	logic [7:0] d;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int irqs = 0;
	int wakes = 0;
	// Open drain wire with pull-up: low when either party pulls it.
	wire sda_line = m_sda & (sda_oe ? sda_o : 1'b1);
	iss_slave i_iss_slave (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.serial_irq(serial_irq), .wake_req(wake_req));
	iss_master_model i_iss_master_model (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
		.sda(m_sda));
	// ------------------------------------------------------------
	// Clock, monitors and timeout
	// ------------------------------------------------------------
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (serial_irq === 1'b1) irqs++;
		if (wake_req === 1'b1) wakes++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] q);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= wsel;
		adr <= a;
		wdat <= v;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] q;
		wb(1'b1, a, {24'h0, v}, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, {24'h0, exp});
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(iss_pkg::OFS_STATUS_CTRL, iss_pkg::STATUS_RESET);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'hff);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'h9b);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h00);
		wsel = 4'h0;
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h1a);
		wsel = 4'hf;
		rd(iss_pkg::OFS_STATUS_CTRL, iss_pkg::STATUS_RESET);
		rd(8'h10, 8'h00);
		wr(iss_pkg::OFS_OWN_ADDR, {ADDR, 1'b0});
		rd(iss_pkg::OFS_OWN_ADDR, {ADDR, 1'b0});
		wr(iss_pkg::OFS_ENABLE, 8'h01);
		rd(iss_pkg::OFS_ENABLE, 8'h01);
		$display("test registers done");
		i_iss_master_model.start();
		rd(iss_pkg::OFS_STATUS_CTRL, 8'h21);
		i_iss_master_model.write_byte({ADDR, 1'b0}, b);
		chk({31'h0, b}, 32'h0);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'he1);
		i_iss_master_model.write_byte(8'ha5, b);
		chk({31'h0, b}, 32'h0);
		rd(iss_pkg::OFS_DATA, 8'ha5);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'h61);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h08);
		i_iss_master_model.write_byte(8'h5a, b);
		chk({31'h0, b}, 32'h1);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'he9);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h00);
		i_iss_master_model.stop();
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hc1);
		chk(irqs, 3);
		$display("test receive done");
		i_iss_master_model.start();
		i_iss_master_model.write_byte({ADDR ^ 7'h01, 1'b0}, b);
		chk({31'h0, b}, 32'h1);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'h21);
		i_iss_master_model.stop();
		rd(iss_pkg::OFS_STATUS_CTRL, 8'h81);
		$display("test mismatch done");
		wr(iss_pkg::OFS_DATA, 8'h3c);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h12);
		i_iss_master_model.start();
		i_iss_master_model.write_byte({ADDR, 1'b1}, b);
		chk({31'h0, b}, 32'h0);
		chk(wakes, 1);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hf7);
		i_iss_master_model.read_byte(1'b0, d);
		chk({24'h0, d}, 32'h3c);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hf6);
		i_iss_master_model.read_byte(1'b1, d);
		chk({24'h0, d}, 32'h3c);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hf7);
		chk(irqs, 6);
		i_iss_master_model.read_byte(1'b1, d);
		chk({24'h0, d}, 32'hff);
		i_iss_master_model.stop();
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hd7);
		wr(iss_pkg::OFS_STATUS_CTRL, 8'h00);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hc5);
		$display("test transmit done");
		wr(iss_pkg::OFS_ENABLE, 8'h00);
		i_iss_master_model.start();
		i_iss_master_model.write_byte({ADDR, 1'b0}, b);
		chk({31'h0, b}, 32'h1);
		rd(iss_pkg::OFS_STATUS_CTRL, 8'hc5);
		i_iss_master_model.stop();
		chk(irqs, 6);
		$display("test disabled done");
		conclude();
	end
endmodule
